// ---- design/plb_logic_block.sv ----
// Purpose: one programmable logic block with sixteen macrocells
// Assumes: pins and clock pins are asynchronous; interconnect is on clk_in
// Notes:   macrocell clocks are sampled levels, edges found on clk_in
//
// Operation
// RQ1: 36 interconnect inputs, 16 macrocells
// RQ2: 32 feedback signals back to interconnect
// RQ3: six control terms, each sum or product
// RQ4: five dedicated product terms per macrocell
// RQ5: 32 shared terms through programmable OR
// RQ6: flip-flop works as D or T
// RQ7: rising or falling clock edge per macrocell
// RQ8: four clocks, first external only
// RQ9: other three external or macrocell driven
// RQ10: first two terms preset and reset
// RQ11: preset and reset disableable per macrocell
// RQ12: power-on reset clears all flip-flops
// RQ13: last four terms select output enable
// RQ14: output buffer forced on or off
// RQ15: enabled float pin low floats all outputs
// RQ16: feedback before and after output buffer
// RQ17: input pins feed back, buried logic too
// RQ18: preset and reset act without clock
// RQ19: toggle inverts on one, else holds
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module plb_logic_block
	import plb_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                        clk_in,
	input  wire logic                        nrst_in,
	input  wire logic                        ce_in,
	// APB slave
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [plb_pkg::ADDR_W-1:0]  paddr_in,
	input  wire logic [plb_pkg::DATA_W-1:0]  pwdata_in,
	output logic      [plb_pkg::DATA_W-1:0]  prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// Central interconnect side
	input  wire logic [plb_pkg::NUM_IN-1:0]  central_interconnect_in,
	output logic      [plb_pkg::NUM_FB-1:0]  central_interconnect_out,
	// Clock pins and float pin
	input  wire logic                        sync_only_clock_in,
	input  wire logic                        flex_clock_a_in,
	input  wire logic                        flex_clock_b_in,
	input  wire logic                        flex_clock_c_in,
	input  wire logic                        global_float_pin_in,
	// Macrocell I/O pins
	input  wire logic [plb_pkg::NUM_MC-1:0]  io_pin_in,
	output logic      [plb_pkg::NUM_MC-1:0]  io_pin_out,
	output logic      [plb_pkg::NUM_MC-1:0]  io_pin_oe_out
);
	import plb_pkg::*;

	// Configuration store
	logic [NUM_IN-1:0]   pal_t_ff [NUM_MC*NUM_PAL];   // PAL true literals
	logic [NUM_IN-1:0]   pal_c_ff [NUM_MC*NUM_PAL];   // PAL complement literals
	logic [NUM_IN-1:0]   pla_t_ff [NUM_PLA];          // PLA true literals
	logic [NUM_IN-1:0]   pla_c_ff [NUM_PLA];          // PLA complement literals
	logic [NUM_PLA-1:0]  or_sel_ff [NUM_MC];          // OR array links
	logic [NUM_IN-1:0]   ct_t_ff [NUM_CT];            // Control term true literals
	logic [NUM_IN-1:0]   ct_c_ff [NUM_CT];            // Control term complements
	logic [NUM_CT-1:0]   ct_prod_ff;                  // One means product mode
	logic [MC_CFG_W-1:0] mc_cfg_ff [NUM_MC];          // Per-macrocell config
	logic [GLB_W-1:0]    glb_ff;                      // Float enable, clock sources

	// Datapath state
	logic [NUM_MC-1:0]   mc_ff;                       // Macrocell flip-flops
	logic [NUM_CLK-1:0]  clk_prev_ff;                 // Clock levels last cycle
	logic [NUM_MC-1:0]   pin_s1_ff;                   // Pin sync stage one
	logic [NUM_MC-1:0]   pin_s2_ff;                   // Pin sync stage two
	logic [4:0]          misc_s1_ff;                  // Clock and float sync one
	logic [4:0]          misc_s2_ff;                  // Clock and float sync two

	// Combinational nets
	logic [9:0]          idx;                         // Word index
	logic [9:0]          off_pla;                     // Offset into PLA region
	logic [9:0]          off_ct;                      // Offset into CT region
	logic [9:0]          off_mc;                      // Offset into MC region
	logic                acc;                         // Access phase, enabled
	logic                wr;                          // Write takes effect
	logic                mapped;                      // Address decodes
	logic [DATA_W-1:0]   rd_data;                     // Read mux
	logic [NUM_PLA-1:0]  pla_term;                    // Shared product terms
	logic [NUM_CT-1:0]   ct_val;                      // Control term values
	logic [NUM_MC-1:0]   mc_d;                        // Macrocell logic input
	logic [NUM_MC-1:0]   mc_q;                        // Value after set/clear
	logic [NUM_MC-1:0]   mc_edge;                     // Selected edge seen
	logic [NUM_MC-1:0]   mc_sc;                       // Set/clear active
	logic [NUM_MC-1:0]   oe_sel;                      // Buffer enable before float
	logic [NUM_MC-1:0]   pin_val;                     // Value after buffer
	logic [NUM_CLK-1:0]  clk_lvl;                     // Current clock levels
	logic                float_act;                   // Float pin in force

	// Product of literals; no literal gives one
	function automatic logic term_and(input logic [NUM_IN-1:0] t,
			input logic [NUM_IN-1:0] c, input logic [NUM_IN-1:0] x);
		term_and = &(~t | x) & &(~c | ~x);
	endfunction

	// Sum of literals; no literal gives zero
	function automatic logic term_or(input logic [NUM_IN-1:0] t,
			input logic [NUM_IN-1:0] c, input logic [NUM_IN-1:0] x);
		term_or = |(t & x) | |(c & ~x);
	endfunction

	// New true mask after a word write
	function automatic logic [NUM_IN-1:0] upd_t(input logic [NUM_IN-1:0] old,
			input logic [1:0] sub, input logic [DATA_W-1:0] wd);
		upd_t = old;
		if (sub == SUB_TRUE) begin
			upd_t[31:0] = wd;
		end else if (sub == SUB_UPPER) begin
			upd_t[35:32] = wd[3:0];
		end
	endfunction

	// New complement mask after a word write
	function automatic logic [NUM_IN-1:0] upd_c(input logic [NUM_IN-1:0] old,
			input logic [1:0] sub, input logic [DATA_W-1:0] wd);
		upd_c = old;
		if (sub == SUB_COMP) begin
			upd_c[31:0] = wd;
		end else if (sub == SUB_UPPER) begin
			upd_c[35:32] = wd[UPPER_COMP_LSB +: 4];
		end
	endfunction

	// Read view of one term; reserved word reads zero
	function automatic logic [DATA_W-1:0] rd_term(input logic [NUM_IN-1:0] t,
			input logic [NUM_IN-1:0] c, input logic [1:0] sub);
		rd_term = '0;
		if (sub == SUB_TRUE) begin
			rd_term = t[31:0];
		end else if (sub == SUB_COMP) begin
			rd_term = c[31:0];
		end else if (sub == SUB_UPPER) begin
			rd_term = {24'h000000, c[35:32], t[35:32]};
		end
	endfunction

	// Address decode; region offsets
	assign idx     = paddr_in[11:2];
	assign off_pla = idx - IDX_PLA_BASE;
	assign off_ct  = idx - IDX_CT_BASE;
	assign off_mc  = idx - IDX_MC_BASE;
	assign acc     = psel_in & penable_in & ce_in;
	assign wr      = acc & pwrite_in;

	// Zero-wait slave, but held off while the block is frozen
	assign pready_out  = ce_in;
	assign pslverr_out = psel_in & penable_in & ~mapped;
	assign prdata_out  = (acc & ~pwrite_in) ? rd_data : '0;

	// Read mux and map check
	always_comb begin
		mapped  = 1'b1;
		rd_data = '0;
		if (idx < IDX_PLA_BASE) begin
			rd_data = rd_term(pal_t_ff[idx[8:2]], pal_c_ff[idx[8:2]], idx[1:0]);
		end else if (idx < IDX_OR_BASE) begin
			rd_data = rd_term(pla_t_ff[off_pla[6:2]], pla_c_ff[off_pla[6:2]], idx[1:0]);
		end else if (idx < IDX_CT_BASE) begin
			rd_data = or_sel_ff[off_pla[3:0]];
		end else if (idx < IDX_CT_MODE) begin
			rd_data = rd_term(ct_t_ff[off_ct[4:2]], ct_c_ff[off_ct[4:2]], idx[1:0]);
		end else if (idx == IDX_CT_MODE) begin
			rd_data = {26'h0000000, ct_prod_ff};
		end else if (idx >= IDX_MC_BASE && idx < IDX_GLOBAL) begin
			rd_data = {19'h00000, mc_cfg_ff[off_mc[3:0]]};
		end else if (idx == IDX_GLOBAL) begin
			rd_data = {28'h0000000, glb_ff};
		end else if (idx == IDX_STATE) begin
			rd_data = {16'h0000, mc_q};
		end else if (idx == IDX_PINS) begin
			rd_data = {16'h0000, pin_val};
		end else begin
			// Holes and space above the map
			mapped = 1'b0;
		end
	end

	// Term arrays; written only, no reset so the fabric stays small
	always_ff @(posedge clk_in) begin
		if (wr) begin
			if (idx < IDX_PLA_BASE) begin
				pal_t_ff[idx[8:2]] <= upd_t(pal_t_ff[idx[8:2]], idx[1:0], pwdata_in);
				pal_c_ff[idx[8:2]] <= upd_c(pal_c_ff[idx[8:2]], idx[1:0], pwdata_in);
			end else if (idx < IDX_OR_BASE) begin
				pla_t_ff[off_pla[6:2]] <= upd_t(pla_t_ff[off_pla[6:2]], idx[1:0],
					pwdata_in);
				pla_c_ff[off_pla[6:2]] <= upd_c(pla_c_ff[off_pla[6:2]], idx[1:0],
					pwdata_in);
			end else if (idx >= IDX_CT_BASE && idx < IDX_CT_MODE) begin
				ct_t_ff[off_ct[4:2]] <= upd_t(ct_t_ff[off_ct[4:2]], idx[1:0], pwdata_in);
				ct_c_ff[off_ct[4:2]] <= upd_c(ct_c_ff[off_ct[4:2]], idx[1:0], pwdata_in);
			end
		end
	end

	// Control registers; reset disables all but the output enables, which then follow control term 2
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ct_prod_ff <= '0;
			glb_ff     <= GLB_RST;
			for (int m = 0; m < NUM_MC; m++) begin
				or_sel_ff[m] <= '0;
				mc_cfg_ff[m] <= MC_CFG_RST;
			end
		end else if (wr) begin
			if (idx >= IDX_OR_BASE && idx < IDX_CT_BASE) begin
				or_sel_ff[off_pla[3:0]] <= pwdata_in;
			end else if (idx == IDX_CT_MODE) begin
				ct_prod_ff <= pwdata_in[NUM_CT-1:0];
			end else if (idx >= IDX_MC_BASE && idx < IDX_GLOBAL) begin
				mc_cfg_ff[off_mc[3:0]] <= pwdata_in[MC_CFG_W-1:0];
			end else if (idx == IDX_GLOBAL) begin
				glb_ff <= pwdata_in[GLB_W-1:0];
			end
		end
	end

	// Pin, clock pin and float pin synchronisers
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pin_s1_ff  <= '0;
			pin_s2_ff  <= '0;
			// Clock stages rest low like the edge history, float stage idle high;
			// any other choice gives a false clock edge right after reset
			misc_s1_ff <= 5'h10;
			misc_s2_ff <= 5'h10;
		end else if (ce_in) begin
			pin_s1_ff  <= io_pin_in;
			pin_s2_ff  <= pin_s1_ff;
			misc_s1_ff <= {global_float_pin_in, flex_clock_c_in, flex_clock_b_in,
				flex_clock_a_in, sync_only_clock_in};
			misc_s2_ff <= misc_s1_ff;
		end
	end

	// Interconnect logic
	always_comb begin
		// RQ3 sum or product
		for (int k = 0; k < NUM_CT; k++) begin
			ct_val[k] = ct_prod_ff[k]
				? term_and(ct_t_ff[k], ct_c_ff[k], central_interconnect_in)
				: term_or(ct_t_ff[k], ct_c_ff[k], central_interconnect_in);
		end
		// RQ5 shared term pool
		for (int j = 0; j < NUM_PLA; j++) begin
			pla_term[j] = term_and(pla_t_ff[j], pla_c_ff[j], central_interconnect_in);
		end
		// RQ4 RQ1 dedicated terms, fixed OR
		for (int m = 0; m < NUM_MC; m++) begin
			mc_d[m] = |(pla_term & or_sel_ff[m]);
			for (int p = 0; p < NUM_PAL; p++) begin
				mc_d[m] = mc_d[m] | (mc_cfg_ff[m][MC_PAL_EN_LSB + p]
					& term_and(pal_t_ff[m*NUM_PAL + p], pal_c_ff[m*NUM_PAL + p],
					central_interconnect_in));
			end
		end
	end

	// Clock levels; a flex clock may come from a macrocell equation
	always_comb begin
		// RQ8 first clock pin only
		clk_lvl[0] = misc_s2_ff[0];
		// RQ9 pin or equation
		for (int k = 1; k < NUM_CLK; k++) begin
			clk_lvl[k] = glb_ff[GLB_ASYNC_LSB + k - 1] ? mc_d[ASYNC_SRC_MC + k - 1]
				: misc_s2_ff[k];
		end
	end

	// Previous clock levels for edge detection
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			clk_prev_ff <= '0;
		end else if (ce_in) begin
			clk_prev_ff <= clk_lvl;
		end
	end

	// Per-macrocell edge and set/clear
	always_comb begin
		for (int m = 0; m < NUM_MC; m++) begin
			// RQ7 polarity per macrocell
			mc_edge[m] = mc_cfg_ff[m][MC_FALL_BIT]
				? (~clk_lvl[mc_cfg_ff[m][MC_CLK_LSB +: 2]]
					& clk_prev_ff[mc_cfg_ff[m][MC_CLK_LSB +: 2]])
				: (clk_lvl[mc_cfg_ff[m][MC_CLK_LSB +: 2]]
					& ~clk_prev_ff[mc_cfg_ff[m][MC_CLK_LSB +: 2]]);
			// RQ10 RQ11 gated terms
			mc_sc[m] = mc_cfg_ff[m][MC_SC_EN_BIT] & (ct_val[0] | ct_val[1]);
			// RQ18 no clock needed; clear wins over preset
			mc_q[m] = mc_sc[m] ? ~ct_val[1] : mc_ff[m];
		end
	end

	// Macrocell flip-flops
	always_ff @(posedge clk_in) begin
		// RQ12 power-on clear
		if (!nrst_in) begin
			mc_ff <= '0;
		end else if (ce_in) begin
			for (int m = 0; m < NUM_MC; m++) begin
				if (mc_sc[m]) begin
					// RQ18 forced value latched so it persists
					mc_ff[m] <= ~ct_val[1];
				end else if (mc_edge[m]) begin
					// RQ6 RQ19 D load or toggle
					mc_ff[m] <= mc_cfg_ff[m][MC_TOGGLE_BIT] ? (mc_ff[m] ^ mc_d[m])
						: mc_d[m];
				end
			end
		end
	end

	// Output buffers
	always_comb begin
		// RQ15 float overrides everything
		float_act = glb_ff[GLB_FLOAT_BIT] & ~misc_s2_ff[4];
		for (int m = 0; m < NUM_MC; m++) begin
			// RQ13 RQ14 enable source
			unique case (mc_cfg_ff[m][MC_OE_LSB +: 3])
				3'h0, 3'h1, 3'h2, 3'h3: oe_sel[m] = ct_val[2 + mc_cfg_ff[m][MC_OE_LSB +: 2]];
				OE_ALWAYS_ON:  oe_sel[m] = 1'b1;
				default:       oe_sel[m] = 1'b0;
			endcase
		end
		io_pin_oe_out = float_act ? '0 : oe_sel;
		// RQ17 undriven pin reads the outside level
		pin_val = (io_pin_oe_out & mc_q) | (~io_pin_oe_out & pin_s2_ff);
	end
	assign io_pin_out = mc_q;

	// Feedback to the interconnect, registered
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			central_interconnect_out <= '0;
		end else if (ce_in) begin
			// RQ2 RQ16 pin half high, macrocell half low
			central_interconnect_out <= {pin_val, mc_q};
		end
	end

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_por_clears: assert property ($rose(nrst_in) |-> mc_ff == '0) // RQ12
		else $error("flip-flops not clear after reset");
	a_float_all: assert property (glb_ff[GLB_FLOAT_BIT] && !misc_s2_ff[4]
		|-> io_pin_oe_out == '0) // RQ15
		else $error("outputs driven while floated");

	for (genvar g = 0; g < NUM_MC; g++) begin : g_chk
		a_clear_now: assert property (mc_cfg_ff[g][MC_SC_EN_BIT] && ct_val[1]
			|-> !mc_q[g]) // RQ10
			else $error("clear term did not clear");
		a_clear_latch: assert property (ce_in && mc_cfg_ff[g][MC_SC_EN_BIT] && ct_val[1]
			|=> !mc_ff[g]) // RQ10
			else $error("clear not held in flip-flop");
		a_sc_disabled: assert property (!mc_cfg_ff[g][MC_SC_EN_BIT] |-> mc_q[g] == mc_ff[g])
			// RQ11
			else $error("set/clear acted while disabled");
		a_toggle_flip: assert property (ce_in && !mc_sc[g] && mc_edge[g]
			&& mc_cfg_ff[g][MC_TOGGLE_BIT] |=> mc_ff[g] == ($past(mc_ff[g]) ^ $past(mc_d[g])))
			// RQ19
			else $error("toggle result wrong");
		a_d_load: assert property (ce_in && !mc_sc[g] && mc_edge[g]
			&& !mc_cfg_ff[g][MC_TOGGLE_BIT] |=> mc_ff[g] == $past(mc_d[g])) // RQ6
			else $error("D load wrong");
		a_hold_edge: assert property (ce_in && !mc_sc[g] && !mc_edge[g]
			|=> $stable(mc_ff[g])) // RQ7
			else $error("flip-flop changed without edge");
		a_oe_forced: assert property (mc_cfg_ff[g][MC_OE_LSB +: 3] == OE_ALWAYS_OFF
			|-> !io_pin_oe_out[g]) // RQ14
			else $error("forced-off buffer driving");
		a_fb_paths: assert property (ce_in |=> central_interconnect_out[g] == $past(mc_q[g])
			&& central_interconnect_out[NUM_MC + g] == $past(pin_val[g])) // RQ16
			else $error("feedback path mismatch");
		a_pin_input: assert property (ce_in && !io_pin_oe_out[g]
			|=> central_interconnect_out[NUM_MC + g] == $past(pin_s2_ff[g])) // RQ17
			else $error("input pin not fed back");
	end
endmodule : plb_logic_block

// ---- design/plb_pkg.sv ----
// Purpose: constants shared by the logic block and its bench
// Assumes: APB word addressing, byte address = index * 4
// Notes:   term masks take four words each, the last one reserved
package plb_pkg;
	// Array sizes
	localparam int NUM_IN  = 36;
	localparam int NUM_MC  = 16;
	localparam int NUM_PAL = 5;
	localparam int NUM_PLA = 32;
	localparam int NUM_CT  = 6;
	localparam int NUM_FB  = 32;
	localparam int NUM_CLK = 4;
	localparam int SYNC_STAGES = 2;
	// Bus widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Word indices of the register regions
	localparam logic [9:0] IDX_PAL_BASE = 10'h000;
	localparam logic [9:0] IDX_PLA_BASE = 10'h140;
	localparam logic [9:0] IDX_OR_BASE  = 10'h1c0;
	localparam logic [9:0] IDX_CT_BASE  = 10'h1d0;
	localparam logic [9:0] IDX_CT_MODE  = 10'h1e8;
	localparam logic [9:0] IDX_MC_BASE  = 10'h1f0;
	localparam logic [9:0] IDX_GLOBAL   = 10'h200;
	localparam logic [9:0] IDX_STATE    = 10'h201;
	localparam logic [9:0] IDX_PINS     = 10'h202;
	// Term word layout: 0 true lits, 1 complement lits, 2 upper bits
	localparam logic [1:0] SUB_TRUE  = 2'h0;
	localparam logic [1:0] SUB_COMP  = 2'h1;
	localparam logic [1:0] SUB_UPPER = 2'h2;
	localparam int UPPER_COMP_LSB = 4;
	// Macrocell config fields
	localparam int MC_CFG_W      = 13;
	localparam int MC_TOGGLE_BIT = 0;
	localparam int MC_FALL_BIT   = 1;
	localparam int MC_CLK_LSB    = 2;
	localparam int MC_SC_EN_BIT  = 4;
	localparam int MC_OE_LSB     = 5;
	localparam int MC_PAL_EN_LSB = 8;
	// Output enable source codes
	localparam logic [2:0] OE_ALWAYS_ON  = 3'h4;
	localparam logic [2:0] OE_ALWAYS_OFF = 3'h5;
	// Global control fields
	localparam int GLB_W         = 4;
	localparam int GLB_FLOAT_BIT = 0;
	localparam int GLB_ASYNC_LSB = 1;
	// Macrocells that drive the flex clocks when asynchronous
	localparam int ASYNC_SRC_MC = 13;
	// Reset values
	localparam logic [MC_CFG_W-1:0] MC_CFG_RST = 13'h0000;
	localparam logic [GLB_W-1:0]    GLB_RST    = 4'h0;
endpackage : plb_pkg

// ---- tb/plb_far_side.sv ----
// Purpose: far side model, interconnect drive and I/O pin wires
// Assumes: bench sets external levels and enables for each pin
// Notes:   released pins show the inverse of their last level
`timescale 1ns/1ns
module plb_far_side
	import plb_pkg::*;
(
	// Clock
	input  wire logic               clk_in,
	// From the bench
	input  wire logic [NUM_IN-1:0]  ci_drive_in,
	input  wire logic [NUM_MC-1:0]  ext_level_in,
	input  wire logic [NUM_MC-1:0]  ext_en_in,
	input  wire logic               float_level_in,
	// Block side
	input  wire logic [NUM_MC-1:0]  io_pin_out_in,
	input  wire logic [NUM_MC-1:0]  io_pin_oe_in,
	output logic      [NUM_MC-1:0]  io_pin_in_out,
	output logic      [NUM_IN-1:0]  central_interconnect_in_out,
	output logic                    global_float_pin_out
);
	logic [NUM_MC-1:0] last_ff; // Last wire level, no pull on pins
	assign central_interconnect_in_out = ci_drive_in;
	assign global_float_pin_out = float_level_in;
	always_comb begin
		for (int i = 0; i < NUM_MC; i++) begin
			if (io_pin_oe_in[i] === 1'b1) begin
				io_pin_in_out[i] = io_pin_out_in[i];
			end else if (ext_en_in[i]) begin
				io_pin_in_out[i] = ext_level_in[i];
			end else begin
				// Floating wire must not keep its old value
				io_pin_in_out[i] = ~last_ff[i];
			end
		end
	end
	// Remember level for floating pins
	always_ff @(posedge clk_in) begin
		last_ff <= io_pin_in_out;
	end
endmodule // plb_far_side

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the logic block
// Assumes: ce held high except in the stall check
// Notes:   clock pins toggled slowly, sync takes two cycles
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module testbench;
	import plb_pkg::*;
	logic clk_in = 0, nrst_in = 0, ce_in = 1;
	logic psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [ADDR_W-1:0] paddr_in = '0;
	logic [DATA_W-1:0] pwdata_in = '0, prdata_out, rdata;
	logic pready_out, pslverr_out, rerr;
	logic [NUM_IN-1:0] ci_drive = '0, ci_in;
	logic [NUM_FB-1:0] ci_out;
	logic [3:0] clk_pins = '0; // Four clock pins
	logic float_lvl = 1;
	logic [NUM_MC-1:0] ext_lvl = '0, ext_en = '0, pin_in, pin_out, pin_oe;
	logic float_pin;
	int n_errors = 0, checks = 0;
	always #25 clk_in = ~clk_in;
	plb_logic_block plb_logic_block_inst (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.central_interconnect_in(ci_in), .central_interconnect_out(ci_out),
		.sync_only_clock_in(clk_pins[0]), .flex_clock_a_in(clk_pins[1]),
		.flex_clock_b_in(clk_pins[2]), .flex_clock_c_in(clk_pins[3]),
		.global_float_pin_in(float_pin), .io_pin_in(pin_in),
		.io_pin_out(pin_out), .io_pin_oe_out(pin_oe));
	plb_far_side plb_far_side_inst (.clk_in(clk_in), .ci_drive_in(ci_drive),
		.ext_level_in(ext_lvl), .ext_en_in(ext_en), .float_level_in(float_lvl),
		.io_pin_out_in(pin_out), .io_pin_oe_in(pin_oe), .io_pin_in_out(pin_in),
		.central_interconnect_in_out(ci_in), .global_float_pin_out(float_pin));
	// Verdict and end of run
	task automatic stop_test();
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// One APB transfer, waits for pready at a rising edge
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1; pwrite_in <= w; paddr_in <= {idx, 2'h0}; pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rdata = prdata_out;
		rerr = pslverr_out;
		psel_in <= 0; penable_in <= 0;
	endtask
	// Term masks: true, complement, upper word
	task automatic term(input logic [9:0] idx, input logic [31:0] t, input logic [31:0] c);
		apb(1, idx, t); apb(1, idx + 10'h1, c); apb(1, idx + 10'h2, 32'h0);
	endtask
	task automatic pulse(input int s, input int n);
		clk_pins[s] <= 1; cyc(n); clk_pins[s] <= 0; cyc(n);
	endtask
	// Reset values, read-back, unmapped place, stall
	task automatic t_bus();
		apb(0, IDX_GLOBAL, 0); `CHK(rdata[GLB_W-1:0], GLB_RST)
		apb(0, IDX_STATE, 0); `CHK(rdata[15:0], 16'h0)
		apb(0, IDX_MC_BASE, 0); `CHK(rdata[MC_CFG_W-1:0], MC_CFG_RST)
		apb(1, 10'h3ff, 32'h1); `CHK(rerr, 1'b1)
		apb(0, 10'h3ff, 0); `CHK(rdata, 32'h0)
		ce_in <= 0; cyc(1); `CHK(pready_out, 1'b0)
		ce_in <= 1;
	endtask
	// Common set-up: control terms known, CT0 and CT2 products
	task automatic t_setup();
		for (int k = 0; k < NUM_CT; k++) term(IDX_CT_BASE + 10'(k * 4), k == 0 ? 2 : 0, 0);
		apb(1, IDX_CT_MODE, 32'h5);
		term(IDX_PAL_BASE, 32'h1, 32'h0); // Mc0 term0 = input 0
		term(IDX_PAL_BASE + 10'h14, 32'h0, 32'h0); // Mc1 term0 empty
		apb(1, IDX_MC_BASE, 32'h180);
		apb(1, IDX_MC_BASE + 10'h1, 32'h107);
	endtask
	// D path through a dedicated term on the sync-only clock
	task automatic t_dpath();
		ci_drive[0] <= 1; pulse(0, 5);
		apb(0, IDX_STATE, 0); `CHK(rdata[0], 1'b1)
		`CHK(pin_out[0], 1'b1)
		`CHK(ci_out[0], 1'b1)
		ci_drive[0] <= 0; pulse(0, 5);
		apb(0, IDX_STATE, 0); `CHK(rdata[0], 1'b0)
	endtask
	// Toggle on falling edge of an external flex clock
	task automatic t_toggle();
		clk_pins[1] <= 1; cyc(6); `CHK(pin_out[1], 1'b0)
		clk_pins[1] <= 0; cyc(6); `CHK(pin_out[1], 1'b1)
		pulse(1, 6); `CHK(pin_out[1], 1'b0)
		// Flex clock a from macrocell 13 equation (input 2)
		ci_drive[2] <= 1;
		term(IDX_PAL_BASE + 10'h104, 32'h4, 32'h0);
		apb(1, IDX_MC_BASE + 10'hd, 32'h100);
		apb(1, IDX_GLOBAL, 32'h2); cyc(3);
		ci_drive[2] <= 0; cyc(3);
		`CHK(pin_out[1], 1'b1)
		apb(1, IDX_GLOBAL, 32'h0); cyc(3);
		`CHK(pin_out[1], 1'b1)
	endtask
	// Preset without clock, disabled on neighbour
	task automatic t_setclr();
		apb(1, IDX_MC_BASE + 10'h2, 32'h10);
		ci_drive[1] <= 1; cyc(2);
		`CHK(pin_out[2], 1'b1)
		`CHK(pin_out[3], 1'b0)
		pulse(0, 5); `CHK(pin_out[2], 1'b1)
		ci_drive[1] <= 0; pulse(0, 5); `CHK(pin_out[2], 1'b0)
	endtask
	// Enable sources, forced states, float pin, pin feedback
	task automatic t_oe();
		apb(1, IDX_MC_BASE + 10'h4, 32'h80); apb(1, IDX_MC_BASE + 10'h5, 32'ha0);
		apb(1, IDX_MC_BASE + 10'h7, 32'h20); cyc(1);
		`CHK(pin_oe[7:4], 4'h5)
		ext_lvl[5] <= 1; ext_en[5] <= 1; cyc(6);
		`CHK(ci_out[21], 1'b1)
		`CHK(ci_out[5], 1'b0)
		apb(1, IDX_GLOBAL, 32'h1); float_lvl <= 0; cyc(5);
		`CHK(pin_oe, 16'h0)
		float_lvl <= 1; cyc(5); `CHK(pin_oe[5:4], 2'h1)
	endtask
	initial begin
		cyc(2);
		nrst_in <= 1;
		t_bus(); t_setup(); t_dpath(); t_toggle(); t_setclr(); t_oe();
		stop_test();
	end
	// Watchdog well past the expected run time
	initial begin
		#2000000;
		n_errors++;
		stop_test();
	end
endmodule // testbench
